// ---- hdl/fop_seq.sv ----
// Notes on behaviour
// - once field holds 64 bytes, eight phrases, in the information area.
// - read once is code 0x04; word 1 holds phrase index 0 to 7.
// - read once fetches the phrase into words 2 to 5, then sets completion.
// - program memory reads return invalid data after the check cycle until read once completes.
// - read once access error on wrong index, forbidden mode or bad phrase.
// - read once errors set verify status bits; never a protection error.
// - program phrase is code 0x06, address in words 0 and 1, data 2 to 5.
// - program phrase writes four words, reads them back, then completes.
// - program phrase access error on wrong index, mode or bad address.
// - program phrase protection error when address falls in protected range.
// - verify errors set high status bit, non-correctable ones the low bit.
// - program once is code 0x07, phrase index in word 1, data 2 to 5.
// - program once checks erased first, then programs and verifies.
// - a second program of a once phrase is refused with access error.
// - program once access error on wrong index, mode or bad phrase.
// - program memory reads return invalid data after the check cycle until program once completes.
`timescale 1ns/100ps
`default_nettype none
`include "fop_cfg.svh"
module fop_seq #(
  parameter logic [23:0] ONCE_BASE = 24'h000000,
  parameter logic [23:0] PF_LO     = 24'h000000,
  parameter logic [23:0] PF_HI     = 24'h03ffff
) (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire fop_pkg::fop_bus_t  bus,
  output logic [15:0]             bus_rdata,
  input  wire logic               cmd_mode_ok,
  input  wire logic               prot_en,
  input  wire logic [17:0]        prot_lo,
  input  wire logic [17:0]        prot_hi,
  output fop_pkg::fop_freq_t      fa_req,
  input  wire fop_pkg::fop_frsp_t fa_rsp,
  output logic                    pf_read_invalid,
  output logic                    busy
);
  fop_pkg::fop_state_t state_r, state_nxt;
  logic        done_r, done_nxt;
  logic        acc_err_r, acc_err_nxt;
  logic        prot_err_r, prot_err_nxt;
  logic        mg1_r, mg1_nxt;
  logic        mg0_r, mg0_nxt;
  logic [2:0]  index_r, index_nxt;
  logic [15:0] w0_r, w0_nxt;
  logic [15:0] w1_r, w1_nxt;
  logic [1:0]  cnt_r, cnt_nxt;
  logic        wait_r, wait_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        rsel_data_r, rsel_data_nxt;

  logic        wr_stat;
  logic        wr_index;
  logic        wr_data;
  logic        launch;
  logic [7:0]  cmd;
  logic [23:0] gaddr;
  logic        addr_ok;
  logic        prot_hit;
  logic        phr_ok;
  logic        chk_acc;
  logic [23:0] once_addr;
  logic [23:0] word_ofs;
  logic        op_ack;
  logic        ram_we;
  logic [2:0]  ram_waddr;
  logic [15:0] ram_wdata;
  logic [2:0]  ram_raddr_b;
  logic [15:0] ram_rdata_a;
  logic [15:0] ram_rdata_b;
  logic        once_cmd;

  assign wr_stat  = bus.wr && (bus.addr == `FOP_OFS_STAT);
  assign wr_index = bus.wr && (bus.addr == `FOP_OFS_INDEX) && done_r;
  assign wr_data  = bus.wr && (bus.addr == `FOP_OFS_DATA) && done_r;
  // launch by writing one to the completion bit while idle and error free
  assign launch   = wr_stat && bus.wdata[`FOP_BIT_DONE] && done_r && !acc_err_r && !prot_err_r
                    && (state_r == fop_pkg::FOP_IDLE);

  assign cmd      = w0_r[15:8];
  assign gaddr    = {w0_r[7:0], w1_r};
  assign addr_ok  = (gaddr >= PF_LO) && (gaddr <= PF_HI)
                    && ((gaddr & `FOP_ALIGN_MASK) == 24'h000000);
  assign prot_hit = prot_en && (gaddr[17:0] >= prot_lo) && (gaddr[17:0] <= prot_hi);
  assign phr_ok   = (w1_r <= `FOP_ONCE_MAX_PHR);

  always_comb begin
    chk_acc = 1'b1;
    case (cmd)
      `FOP_CMD_READ_ONCE: chk_acc = (index_r != `FOP_IX_READ_ONCE) || !cmd_mode_ok || !phr_ok;
      `FOP_CMD_PROG_PHR:  chk_acc = (index_r != `FOP_IX_PROG) || !cmd_mode_ok || !addr_ok;
      `FOP_CMD_PROG_ONCE: chk_acc = (index_r != `FOP_IX_PROG) || !cmd_mode_ok || !phr_ok;
      default:            chk_acc = 1'b1;
    endcase
  end

  // once field: eight phrases of eight bytes above ONCE_BASE
  assign word_ofs  = {22'h000000, cnt_r} * `FOP_WORD_BYTES;
  assign once_addr = ONCE_BASE + (w1_r[2:0] * `FOP_PHR_BYTES) + word_ofs;

  assign once_cmd = (cmd == `FOP_CMD_READ_ONCE) || (cmd == `FOP_CMD_PROG_ONCE);
  assign busy     = !done_r;
  assign pf_read_invalid = busy && (state_r != fop_pkg::FOP_CHECK) && once_cmd;

  assign ram_raddr_b = `FOP_W_DATA0 + {1'b0, cnt_r};

  always_comb begin
    fa_req       = '0;
    fa_req.req   = !wait_r && ((state_r == fop_pkg::FOP_RD) || (state_r == fop_pkg::FOP_PRE)
                   || (state_r == fop_pkg::FOP_PRG) || (state_r == fop_pkg::FOP_VFY));
    fa_req.prog  = (state_r == fop_pkg::FOP_PRG);
    fa_req.info  = (cmd != `FOP_CMD_PROG_PHR);
    fa_req.addr  = (cmd == `FOP_CMD_PROG_PHR) ? (gaddr + word_ofs) : once_addr;
    fa_req.wdata = ram_rdata_b;
  end

  assign op_ack = fa_req.req && fa_rsp.ack;

  // parameter words: bus writes while idle, read once results while busy
  always_comb begin
    ram_we    = wr_data;
    ram_waddr = index_r;
    ram_wdata = bus.wdata;
    if ((state_r == fop_pkg::FOP_RD) && op_ack) begin
      ram_we    = 1'b1;
      ram_waddr = ram_raddr_b;
      ram_wdata = fa_rsp.rdata;
    end
  end

  fop_wram #(
    .W  (16),
    .D  (8),
    .AW (3)
  ) u_wram (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .we      (ram_we),
    .waddr   (ram_waddr),
    .wdata   (ram_wdata),
    .raddr_a (index_r),
    .rdata_a (ram_rdata_a),
    .raddr_b (ram_raddr_b),
    .rdata_b (ram_rdata_b)
  );

  always_comb begin
    state_nxt     = state_r;
    done_nxt      = done_r;
    acc_err_nxt   = acc_err_r;
    prot_err_nxt  = prot_err_r;
    mg1_nxt       = mg1_r;
    mg0_nxt       = mg0_r;
    index_nxt     = index_r;
    w0_nxt        = w0_r;
    w1_nxt        = w1_r;
    cnt_nxt       = cnt_r;
    wait_nxt      = 1'b0;
    rdata_nxt     = 16'h0000;
    rsel_data_nxt = 1'b0;

    // software clears of the error flags; hardware sets below win
    if (wr_stat && bus.wdata[`FOP_BIT_ACC_ERR]) begin
      acc_err_nxt = 1'b0;
    end
    if (wr_stat && bus.wdata[`FOP_BIT_PROT_ERR]) begin
      prot_err_nxt = 1'b0;
    end
    if (wr_index) begin
      index_nxt = bus.wdata[2:0];
    end
    if (wr_data && (index_r == 3'h0)) begin
      w0_nxt = bus.wdata;
    end
    if (wr_data && (index_r == 3'h1)) begin
      w1_nxt = bus.wdata;
    end

    if (bus.rd) begin
      case (bus.addr)
        `FOP_OFS_STAT: begin
          rdata_nxt[`FOP_BIT_DONE]     = done_r;
          rdata_nxt[`FOP_BIT_ACC_ERR]  = acc_err_r;
          rdata_nxt[`FOP_BIT_PROT_ERR] = prot_err_r;
          rdata_nxt[`FOP_BIT_VFY_HI]   = mg1_r;
          rdata_nxt[`FOP_BIT_VFY_LO]   = mg0_r;
        end
        `FOP_OFS_INDEX: rdata_nxt = {13'h0000, index_r};
        `FOP_OFS_DATA:  rsel_data_nxt = 1'b1;
        default:        rdata_nxt = 16'h0000;
      endcase
    end

    case (state_r)
      fop_pkg::FOP_IDLE: begin
        if (launch) begin
          done_nxt  = 1'b0;
          mg1_nxt   = 1'b0;
          mg0_nxt   = 1'b0;
          state_nxt = fop_pkg::FOP_CHECK;
        end
      end
      fop_pkg::FOP_CHECK: begin
        cnt_nxt  = 2'h0;
        wait_nxt = 1'b1;
        if (chk_acc) begin
          acc_err_nxt = 1'b1;
          state_nxt  = fop_pkg::FOP_DONE;
        end else if ((cmd == `FOP_CMD_PROG_PHR) && prot_hit) begin
          prot_err_nxt = 1'b1;
          state_nxt  = fop_pkg::FOP_DONE;
        end else if (cmd == `FOP_CMD_READ_ONCE) begin
          state_nxt = fop_pkg::FOP_RD;
        end else if (cmd == `FOP_CMD_PROG_ONCE) begin
          state_nxt = fop_pkg::FOP_PRE;
        end else begin
          state_nxt = fop_pkg::FOP_PRG;
        end
      end
      fop_pkg::FOP_RD: begin
        if (op_ack) begin
          mg1_nxt  = mg1_r | fa_rsp.err | fa_rsp.nce;
          mg0_nxt  = mg0_r | fa_rsp.nce;
          cnt_nxt  = cnt_r + 2'h1;
          wait_nxt = 1'b1;
          if (cnt_r == `FOP_WORDS_LAST) begin
            state_nxt = fop_pkg::FOP_DONE;
          end
        end
      end
      fop_pkg::FOP_PRE: begin
        if (op_ack) begin
          cnt_nxt  = cnt_r + 2'h1;
          wait_nxt = 1'b1;
          if (fa_rsp.rdata != `FOP_ERASED_WORD) begin
            acc_err_nxt = 1'b1;
            state_nxt  = fop_pkg::FOP_DONE;
          end else if (cnt_r == `FOP_WORDS_LAST) begin
            state_nxt = fop_pkg::FOP_PRG;
          end
        end
      end
      fop_pkg::FOP_PRG: begin
        if (op_ack) begin
          cnt_nxt  = cnt_r + 2'h1;
          wait_nxt = 1'b1;
          if (cnt_r == `FOP_WORDS_LAST) begin
            state_nxt = fop_pkg::FOP_VFY;
          end
        end
      end
      fop_pkg::FOP_VFY: begin
        if (op_ack) begin
          mg1_nxt  = mg1_r | fa_rsp.err | fa_rsp.nce | (fa_rsp.rdata != ram_rdata_b);
          mg0_nxt  = mg0_r | fa_rsp.nce;
          cnt_nxt  = cnt_r + 2'h1;
          wait_nxt = 1'b1;
          if (cnt_r == `FOP_WORDS_LAST) begin
            state_nxt = fop_pkg::FOP_DONE;
          end
        end
      end
      fop_pkg::FOP_DONE: begin
        done_nxt  = 1'b1;
        state_nxt = fop_pkg::FOP_IDLE;
      end
      default: begin
        done_nxt  = 1'b1;
        state_nxt = fop_pkg::FOP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r     <= fop_pkg::FOP_IDLE;
      done_r      <= `FOP_RST_DONE;
      acc_err_r   <= 1'b0;
      prot_err_r  <= 1'b0;
      mg1_r       <= 1'b0;
      mg0_r       <= 1'b0;
      index_r     <= `FOP_RST_INDEX;
      w0_r        <= `FOP_RST_WORD;
      w1_r        <= `FOP_RST_WORD;
      cnt_r       <= 2'h0;
      wait_r      <= 1'b0;
      rdata_r     <= 16'h0000;
      rsel_data_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      done_r      <= done_nxt;
      acc_err_r   <= acc_err_nxt;
      prot_err_r  <= prot_err_nxt;
      mg1_r       <= mg1_nxt;
      mg0_r       <= mg0_nxt;
      index_r     <= index_nxt;
      w0_r        <= w0_nxt;
      w1_r        <= w1_nxt;
      cnt_r       <= cnt_nxt;
      wait_r      <= wait_nxt;
      rdata_r     <= rdata_nxt;
      rsel_data_r <= rsel_data_nxt;
    end
  end

  // read data stand only in the cycle after the strobe
  assign bus_rdata = rsel_data_r ? ram_rdata_a : rdata_r;

endmodule // fop_seq
`default_nettype wire

// ---- hdl/fop_cfg.svh ----
`ifndef FOP_CFG_SVH
`define FOP_CFG_SVH

// register offsets on the plain register port
`define FOP_OFS_STAT      3'h0
`define FOP_OFS_INDEX     3'h1
`define FOP_OFS_DATA      3'h2

// status register bit positions
`define FOP_BIT_DONE      7
`define FOP_BIT_ACC_ERR   5
`define FOP_BIT_PROT_ERR  4
`define FOP_BIT_VFY_HI    1
`define FOP_BIT_VFY_LO    0

// reset values
`define FOP_RST_DONE      1'b1
`define FOP_RST_INDEX     3'h0
`define FOP_RST_WORD      16'h0000

// command codes in the high byte of parameter word 0
`define FOP_CMD_READ_ONCE 8'h04
`define FOP_CMD_PROG_PHR  8'h06
`define FOP_CMD_PROG_ONCE 8'h07

// parameter index value required at launch
`define FOP_IX_READ_ONCE  3'h1
`define FOP_IX_PROG       3'h5

// once field geometry and parameter word layout
`define FOP_ONCE_MAX_PHR  16'h0007
`define FOP_PHR_BYTES     24'h000008
`define FOP_WORD_BYTES    24'h000002
`define FOP_W_DATA0       3'h2
`define FOP_WORDS_LAST    2'h3
`define FOP_ERASED_WORD   16'hffff
`define FOP_ALIGN_MASK    24'h000007

`endif

// ---- hdl/fop_pkg.sv ----
`default_nettype none
package fop_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [2:0]  addr;
    logic [15:0] wdata;
  } fop_bus_t;

  typedef struct packed {
    logic        req;
    logic        prog;
    logic        info;
    logic [23:0] addr;
    logic [15:0] wdata;
  } fop_freq_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic        nce;
    logic [15:0] rdata;
  } fop_frsp_t;

  typedef enum logic [2:0] {
    FOP_IDLE  = 3'h0,
    FOP_CHECK = 3'h1,
    FOP_PRE   = 3'h3,
    FOP_PRG   = 3'h2,
    FOP_VFY   = 3'h6,
    FOP_RD    = 3'h7,
    FOP_DONE  = 3'h5
  } fop_state_t;

endpackage
`default_nettype wire

// ---- hdl/fop_wram.sv ----
`timescale 1ns/100ps
`default_nettype none
module fop_wram #(
  parameter int W  = 16,
  parameter int D  = 8,
  parameter int AW = 3
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr_a,
  output logic      [W-1:0]  rdata_a,
  input  wire logic [AW-1:0] raddr_b,
  output logic      [W-1:0]  rdata_b
);
  logic [W-1:0] mem [D];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
endmodule // fop_wram
`default_nettype wire

// ---- sim/fop_seq_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module fop_seq_sva #(
  parameter logic [23:0] ONCE_BASE = 24'h000000
) (
  input wire logic               mclk,
  input wire logic               rst_n,
  input wire fop_pkg::fop_freq_t fa_req,
  input wire fop_pkg::fop_frsp_t fa_rsp,
  input wire logic               pf_read_invalid,
  input wire logic               busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_wait2;
    !fa_req.req ##1 !fa_req.req;
  endsequence
  property p_start; $rose(busy) |-> s_wait2; endproperty
  a_start: assert property (p_start) else $error("array request too early");
  property p_hold;
    fa_req.req && !fa_rsp.ack |=> fa_req.req && $stable(fa_req.addr) && $stable(fa_req.wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("array request changed before ack");
  property p_gap; fa_req.req && fa_rsp.ack |=> !fa_req.req; endproperty
  a_gap: assert property (p_gap) else $error("no idle cycle after ack");
  property p_quiet; !busy |-> !fa_req.req; endproperty
  a_quiet: assert property (p_quiet) else $error("array request while complete");
  property p_inv; fa_req.req && fa_req.info |-> pf_read_invalid; endproperty
  a_inv: assert property (p_inv) else $error("reads not invalid during once access");
  property p_invb; pf_read_invalid |-> busy; endproperty
  a_invb: assert property (p_invb) else $error("reads invalid while idle");
  property p_field; fa_req.req && fa_req.info |-> (fa_req.addr - ONCE_BASE) < 24'h000040; endproperty
  a_field: assert property (p_field) else $error("once access outside field");
  property p_word; fa_req.req |-> fa_req.addr[0] == 1'b0; endproperty
  a_word: assert property (p_word) else $error("odd word address");
endmodule // fop_seq_sva
bind fop_seq fop_seq_sva #(.ONCE_BASE(ONCE_BASE)) u_sva (.mclk(mclk), .rst_n(rst_n), .fa_req(fa_req),
  .fa_rsp(fa_rsp), .pf_read_invalid(pf_read_invalid), .busy(busy));
`default_nettype wire

// ---- sim/test_fop_seq.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "fop_cfg.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module test_fop_seq;
  localparam logic [7:0] OK_S = 8'h80;
  localparam logic [7:0] AE_S = 8'ha0;
  localparam logic [7:0] PV_S = 8'h90;
  logic               mclk        = 1'b0;
  logic               rst_n       = 1'b0;
  fop_pkg::fop_bus_t  bus         = '0;
  logic               cmd_mode_ok = 1'b1;
  logic               prot_en     = 1'b0;
  logic [17:0]        prot_lo     = 18'h00100;
  logic [17:0]        prot_hi     = 18'h001ff;
  fop_pkg::fop_frsp_t fa_rsp      = '0;
  fop_pkg::fop_freq_t fa_req;
  logic [15:0]        bus_rdata;
  logic               pf_inv;
  logic               busy;
  logic [1:0]         inj         = 2'h0;
  logic               inv_seen    = 1'b0;
  int                 last_n      = 0;
  logic [15:0]        rd_v;
  logic [15:0]        pw [0:5];
  logic [15:0]        imem [0:31];
  logic [15:0]        pmem [0:15];
  int                 tests_run   = 0;
  int                 bad_count   = 0;

  always #4 mclk = ~mclk;

  fop_seq dut_u (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .bus             (bus),
    .bus_rdata       (bus_rdata),
    .cmd_mode_ok     (cmd_mode_ok),
    .prot_en         (prot_en),
    .prot_lo         (prot_lo),
    .prot_hi         (prot_hi),
    .fa_req          (fa_req),
    .fa_rsp          (fa_rsp),
    .pf_read_invalid (pf_inv),
    .busy            (busy)
  );

  // array stand-in: acks a cycle after the request, read data toggles outside ack
  always @(posedge mclk) begin
    if (fa_req.req && !fa_rsp.ack) begin
      fa_rsp.ack   <= 1'b1;
      fa_rsp.err   <= inj[1];
      fa_rsp.nce   <= inj[0];
      fa_rsp.rdata <= fa_req.info ? imem[fa_req.addr[5:1]] : pmem[fa_req.addr[4:1]];
      if (fa_req.prog && fa_req.info) imem[fa_req.addr[5:1]] <= imem[fa_req.addr[5:1]] & fa_req.wdata;
      else if (fa_req.prog) pmem[fa_req.addr[4:1]] <= pmem[fa_req.addr[4:1]] & fa_req.wdata;
    end else begin
      fa_rsp.ack   <= 1'b0;
      fa_rsp.err   <= 1'b0;
      fa_rsp.nce   <= 1'b0;
      fa_rsp.rdata <= ~fa_rsp.rdata;
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    bus <= '0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    bus <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge mclk);
    bus <= '0;
    #1 rd_v = bus_rdata;
  endtask

  // loads words 0 to 5, launches, waits for completion, reads status and clears both error flags
  task automatic run(input logic [15:0] w0, input logic [15:0] w1, input logic [2:0] ix);
    int n;
    pw[0] = w0;
    pw[1] = w1;
    for (int i = 0; i < 6; i++) begin
      wr(`FOP_OFS_INDEX, 16'(i));
      wr(`FOP_OFS_DATA, pw[i]);
    end
    wr(`FOP_OFS_INDEX, {13'h0000, ix});
    wr(`FOP_OFS_STAT, 16'h0080);
    n = 0;
    inv_seen = 1'b0;
    do begin
      @(posedge mclk);
      #1 n++;
      if (pf_inv === 1'b1) inv_seen = 1'b1;
    end while (busy !== 1'b0 && n < 200);
    last_n = n;
    if (n == 200) begin
      bad_count++;
      conclude();
    end
    rd(`FOP_OFS_STAT);
    wr(`FOP_OFS_STAT, 16'h0030);
  endtask

  task automatic t_reset();
    `CHK(busy, 1'b0);
    `CHK(pf_inv, 1'b0);
    rd(`FOP_OFS_STAT);
    `CHK(rd_v[7:0], OK_S);
    rd(3'h7);
    `CHK(rd_v, 16'h0000);
  endtask

  task automatic t_ro_bad();
    run(16'h0400, 16'h0003, 3'h0);
    `CHK(rd_v[7:0], AE_S);
    `CHK(last_n, 2);
    run(16'h0500, 16'h0003, 3'h1);
    `CHK(rd_v[7:0], AE_S);
    `CHK(last_n, 2);
    run(16'h0400, 16'h0008, 3'h1);
    `CHK(rd_v[7:0], AE_S);
    cmd_mode_ok <= 1'b0;
    run(16'h0400, 16'h0003, 3'h1);
    `CHK(rd_v[7:0], AE_S);
    cmd_mode_ok <= 1'b1;
  endtask

  task automatic t_po();
    for (int i = 2; i < 6; i++) pw[i] = 16'ha5c0 + 16'(i);
    run(16'h0700, 16'h0003, 3'h5);
    `CHK(rd_v[7:0], OK_S);
    `CHK(imem[13], 16'ha5c3);
    `CHK(inv_seen, 1'b1);
    for (int i = 2; i < 6; i++) pw[i] = 16'h0000;
    run(16'h0400, 16'h0003, 3'h1);
    `CHK(rd_v[7:0], OK_S);
    `CHK(inv_seen, 1'b1);
    for (int i = 2; i < 6; i++) begin
      wr(`FOP_OFS_INDEX, 16'(i));
      rd(`FOP_OFS_DATA);
      `CHK(rd_v, 16'ha5c0 + 16'(i));
    end
    run(16'h0700, 16'h0003, 3'h5);
    `CHK(rd_v[7:0], AE_S);
    `CHK(imem[13], 16'ha5c3);
    run(16'h0700, 16'h0008, 3'h5);
    `CHK(rd_v[7:0], AE_S);
    run(16'h0700, 16'h0001, 3'h1);
    `CHK(rd_v[7:0], AE_S);
  endtask

  task automatic t_pp();
    for (int i = 2; i < 6; i++) pw[i] = 16'h3c00 + 16'(i);
    run(16'h0600, 16'h0012, 3'h5);
    `CHK(rd_v[7:0], AE_S);
    run(16'h0600, 16'h0010, 3'h4);
    `CHK(rd_v[7:0], AE_S);
    run(16'h0604, 16'h0000, 3'h5);
    `CHK(rd_v[7:0], AE_S);
    prot_en <= 1'b1;
    run(16'h0600, 16'h0100, 3'h5);
    `CHK(rd_v[7:0], PV_S);
    run(16'h0600, 16'h0010, 3'h5);
    `CHK(rd_v[7:0], OK_S);
    `CHK(inv_seen, 1'b0);
    `CHK(pmem[8], 16'h3c02);
    `CHK(pmem[11], 16'h3c05);
  endtask

  task automatic t_err();
    inj <= 2'h2;
    run(16'h0600, 16'h0018, 3'h5);
    `CHK(rd_v[7:0], 8'h82);
    inj <= 2'h3;
    run(16'h0400, 16'h0003, 3'h1);
    `CHK(rd_v[7:0], 8'h83);
    inj <= 2'h0;
    prot_en <= 1'b0;
  endtask

  initial begin
    for (int i = 0; i < 32; i++) imem[i] = 16'hffff;
    for (int i = 0; i < 16; i++) pmem[i] = 16'hffff;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_ro_bad();
    t_po();
    t_pp();
    t_err();
    conclude();
  end
endmodule // test_fop_seq
`default_nettype wire
